// >>> ctoc_regs.vh
// Register map, configuration codes and timing counts of the ETU timeout counter
`ifndef CTOC_REGS_VH
`define CTOC_REGS_VH

// Register byte offsets
`define CTOC_ADDR_CFG     8'h08
`define CTOC_ADDR_RLD_LO  8'h09
`define CTOC_ADDR_RLD_MID 8'h0A
`define CTOC_ADDR_RLD_HI  8'h0B
`define CTOC_ADDR_STAT    8'h0E
`define CTOC_ADDR_RUN     8'h0F

// Reset value of every register
`define CTOC_RST_BYTE     8'h00

// Configuration codes
`define CTOC_CFG_STOP     8'h00
`define CTOC_CFG_LO       8'h05
`define CTOC_CFG_PAIR     8'h61
`define CTOC_CFG_DUAL     8'h65
`define CTOC_CFG_CHAIN    8'h68
`define CTOC_CFG_PAIR_T   8'h71
`define CTOC_CFG_DUAL_T   8'h75
`define CTOC_CFG_CHAIN_T  8'h7C
`define CTOC_CFG_LO_S     8'h85
`define CTOC_CFG_DUAL_S   8'hE5
`define CTOC_CFG_PAIR_TS  8'hF1
`define CTOC_CFG_DUAL_TS  8'hF5

// Status bit positions
`define CTOC_ST_SHORT     0
`define CTOC_ST_LONG      1

// Run register bit positions
`define CTOC_RUN_LO       0
`define CTOC_RUN_HI       1
`define CTOC_RUN_LO_ARM   2
`define CTOC_RUN_HI_TRIG  3
`define CTOC_RUN_CHAIN    4

// ETUs after the start bit before the automatic stop
`define CTOC_STOP_ETUS    4'hC

// Answer-to-reset card clock windows
`define CTOC_ATR_MIN      9'h0C8
`define CTOC_ATR_MAX      9'h170

`endif

// >>> ctoc_sync.v
// Two-stage synchroniser for the card I/O line
`timescale 1ns/1ns
`default_nettype none

module ctoc_sync (
  input  wire mclk_i,    // System clock
  input  wire sys_rst_i, // Asynchronous reset, high
  input  wire async_i,   // Level from the pin
  output reg  sync_o     // Level in the clock domain
);

  reg meta_r; // First stage, read only by the second

  // Two flip-flops; the line idles high
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_r <= 1'b1;
      sync_o <= 1'b1;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule // ctoc_sync

`default_nettype wire

// >>> ctoc_atr_cnt.v
// Card clock window counter used during answer-to-reset
`include "ctoc_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module ctoc_atr_cnt (
  input  wire mclk_i,          // System clock
  input  wire sys_rst_i,       // Asynchronous reset, high
  input  wire start_session_i, // Session running
  input  wire card_clk_tick_i, // One pulse per card clock
  output reg  atr_min_done_o,  // 200 card clocks elapsed
  output reg  atr_max_done_o   // Maximum card clocks elapsed
);

  reg [8:0] clk_cnt_r; // Card clocks since session start

  // R19 hardware window count
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clk_cnt_r      <= 9'h000;
      atr_min_done_o <= 1'b0;
      atr_max_done_o <= 1'b0;
    end else if (!start_session_i) begin
      // Cleared while no session runs
      clk_cnt_r      <= 9'h000;
      atr_min_done_o <= 1'b0;
      atr_max_done_o <= 1'b0;
    end else if (card_clk_tick_i && !atr_max_done_o) begin
      // Saturates at the maximum window
      clk_cnt_r <= clk_cnt_r + 9'h001;
      if (clk_cnt_r + 9'h001 == `CTOC_ATR_MIN) begin
        atr_min_done_o <= 1'b1;
      end
      if (clk_cnt_r + 9'h001 == `CTOC_ATR_MAX) begin
        atr_max_done_o <= 1'b1;
      end
    end
  end

endmodule // ctoc_atr_cnt

`default_nettype wire

// >>> ctoc_top.v
// ETU timeout counter with reload, configuration and status registers
// What this block does and what its host must do
// R1 - 61H: low idle, pair starts on write
// R2 - Host stops pair before reloading mid/high
// R3 - 65H: low auto-reloads from first start bit
// R4 - 65H: pair starts on write, sets long flag
// R5 - Host writes 05H before mid/high reload
// R6 - Host leaves low reload alone while counting
// R7 - Code 00H halts every running stage
// R8 - 68H: 24-bit chain starts on write
// R9 - Host leaves reloads alone in 68H
// R10 - 71H: pair starts, retriggers on start bits
// R11 - Reload writes apply at next start bit
// R12 - 75H: auto-reload low plus retriggered pair
// R13 - 7CH: retriggered 24-bit chain
// R14 - Host never loads all reloads zero
// R15 - 85H: like 05H, stop after 12 ETUs
// R16 - E5H/F1H/F5H stop chosen stages after 12 ETUs
// R17 - Host writes config only with active card
// R18 - Host writes 00H before restarting pair/chain
// R19 - Hardware counts 200 and 368 card clocks
// R20 - Reloads at 09H-0BH, low to high, reset zero
// R21 - 05H stops pair, low keeps auto-reloading
// R22 - 00H reset value, everything stopped
// R23 - Host writes only listed codes
// R24 - Stages advance per ETU tick to value
//
// Added by the designer: strobed register access and the register addresses.
`include "ctoc_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module ctoc_top (
  input  wire       mclk_i,          // System clock, 50 MHz
  input  wire       sys_rst_i,       // Asynchronous reset, high
  input  wire [7:0] addr_i,          // Register address
  input  wire [7:0] wdata_i,         // Write data
  input  wire       wr_i,            // Write strobe
  input  wire       rd_i,            // Read strobe
  output reg  [7:0] rdata_o,         // Read data, cycle after strobe
  input  wire       etu_tick_i,      // One pulse per ETU
  input  wire       card_io_i,       // Card I/O pin level
  input  wire       tx_busy_i,       // Transmitter owns the line
  input  wire       tx_start_i,      // Transmitted start bit pulse
  input  wire       start_session_i, // Answer-to-reset session
  input  wire       card_clk_tick_i, // One pulse per card clock
  output reg        timeout_irq_o,   // Interrupt while a flag is set
  output wire       atr_min_done_o,  // 200 card clocks elapsed
  output wire       atr_max_done_o   // Maximum card clocks elapsed
);

  // One-hot states of the automatic stop sequencer
  localparam [3:0] TW_IDLE = 4'b0001; // No stop pending
  localparam [3:0] TW_ARM  = 4'b0010; // Waiting for start bit
  localparam [3:0] TW_CNT  = 4'b0100; // Counting ETUs
  localparam [3:0] TW_DONE = 4'b1000; // Stop has happened

  // Mode decode bit positions
  localparam M_LO_ARM  = 0; // Arm low auto-reload
  localparam M_LO_KEEP = 1; // Leave low stage as is
  localparam M_HI_LOAD = 2; // Start pair or chain on write
  localparam M_HI_TRIG = 3; // Pair or chain on start bits
  localparam M_CHAIN   = 4; // 24-bit chain
  localparam M_TW_ON   = 5; // Automatic stop enabled
  localparam M_HALT_LO = 6; // Stop halts low stage
  localparam M_HALT_HI = 7; // Stop halts pair

  reg  [7:0]  cfg_r;         // Configuration code
  reg  [7:0]  rld_lo_r;      // Low reload byte
  reg  [7:0]  rld_mid_r;     // Middle reload byte
  reg  [7:0]  rld_hi_r;      // High reload byte
  reg  [1:0]  stat_r;        // Short and long flags
  reg  [1:0]  stat_nxt;      // Next flags
  reg  [7:0]  lo_cnt_r;      // Low stage remaining ETUs
  reg         lo_run_r;      // Low stage counting
  reg         lo_arm_r;      // Low stage waiting for start bit
  reg  [23:0] hi_cnt_r;      // Pair or chain remaining ETUs
  reg         hi_run_r;      // Pair or chain counting
  reg         hi_trig_r;     // Start bits reload pair or chain
  reg  [3:0]  tw_st_r;       // Stop sequencer state
  reg  [3:0]  tw_cnt_r;      // ETUs since start bit
  reg         io_d_r;        // Delayed synced I/O level
  wire        io_sync;       // Synced I/O level
  wire        rx_start;      // Received start bit
  wire        any_start;     // Any start bit
  wire [7:0]  wmode;         // Decode of written code
  wire [7:0]  cmode;         // Decode of current code
  wire        cfg_wr;        // Configuration write
  wire        lo_tc;         // Low stage terminal count
  wire        hi_tc;         // Pair or chain terminal count
  wire        tw_fire;       // Automatic stop this cycle
  wire        halt_lo;       // Stop low stage now
  wire        halt_hi;       // Stop pair now
  wire [23:0] hi_load;       // Load value for pair or chain
  wire        stat_rd;       // Status read clears flags

  // Decode a configuration code into control bits
  function [7:0] f_mode;
    input [7:0] code;
    begin
      case (code)
        `CTOC_CFG_LO:      f_mode = 8'h02;
        `CTOC_CFG_PAIR:    f_mode = 8'h04;
        `CTOC_CFG_DUAL:    f_mode = 8'h05;
        `CTOC_CFG_CHAIN:   f_mode = 8'h14;
        `CTOC_CFG_PAIR_T:  f_mode = 8'h08;
        `CTOC_CFG_DUAL_T:  f_mode = 8'h09;
        `CTOC_CFG_CHAIN_T: f_mode = 8'h18;
        `CTOC_CFG_LO_S:    f_mode = 8'hE2;
        `CTOC_CFG_DUAL_S:  f_mode = 8'h65;
        `CTOC_CFG_PAIR_TS: f_mode = 8'hA8;
        `CTOC_CFG_DUAL_TS: f_mode = 8'hE9;
        default:           f_mode = 8'h00;
      endcase
    end
  endfunction

  // Terminal count: elapsed ETUs reach the loaded value
  function f_tc;
    input [23:0] left;
    begin
      f_tc = (left <= 24'h000001);
    end
  endfunction

  // Card I/O line into the clock domain
  ctoc_sync u_io_sync (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (card_io_i),
    .sync_o    (io_sync)
  );

  // R19 window counter
  ctoc_atr_cnt u_atr (
    .mclk_i          (mclk_i),
    .sys_rst_i       (sys_rst_i),
    .start_session_i (start_session_i),
    .card_clk_tick_i (card_clk_tick_i),
    .atr_min_done_o  (atr_min_done_o),
    .atr_max_done_o  (atr_max_done_o)
  );

  // Falling edge on the line outside transmission is a received start
  assign rx_start  = io_d_r & ~io_sync & ~tx_busy_i;
  assign any_start = rx_start | tx_start_i;

  assign cfg_wr  = wr_i && (addr_i == `CTOC_ADDR_CFG);
  assign stat_rd = rd_i && (addr_i == `CTOC_ADDR_STAT);
  assign wmode   = f_mode(wdata_i);
  assign cmode   = f_mode(cfg_r);

  // R24 terminal detection per stage
  assign lo_tc = f_tc({16'h0000, lo_cnt_r});
  assign hi_tc = f_tc(hi_cnt_r);

  // Chain takes the low byte; the pair leaves it to the low stage
  assign hi_load = cmode[M_CHAIN] ? {rld_hi_r, rld_mid_r, rld_lo_r}
                                  : {8'h00, rld_hi_r, rld_mid_r};

  // R15 end of the 12th ETU after the start bit
  assign tw_fire = (tw_st_r == TW_CNT) && etu_tick_i &&
                   (tw_cnt_r == `CTOC_STOP_ETUS - 4'h1);
  // R16 stage selection for the stop
  assign halt_lo = tw_fire & cmode[M_HALT_LO];
  assign halt_hi = tw_fire & cmode[M_HALT_HI];

  // Edge detector delay on the synced line
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      io_d_r <= 1'b1;
    end else begin
      io_d_r <= io_sync;
    end
  end

  // Register writes
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      // R22 stopped code after reset
      cfg_r     <= `CTOC_RST_BYTE;
      // R20 reloads clear at reset
      rld_lo_r  <= `CTOC_RST_BYTE;
      rld_mid_r <= `CTOC_RST_BYTE;
      rld_hi_r  <= `CTOC_RST_BYTE;
    end else if (wr_i) begin
      // R20 address decode of reloads
      if (addr_i == `CTOC_ADDR_CFG) begin
        cfg_r <= wdata_i;
      end else if (addr_i == `CTOC_ADDR_RLD_LO) begin
        rld_lo_r <= wdata_i;
      end else if (addr_i == `CTOC_ADDR_RLD_MID) begin
        rld_mid_r <= wdata_i;
      end else if (addr_i == `CTOC_ADDR_RLD_HI) begin
        rld_hi_r <= wdata_i;
      end
    end
  end

  // Low 8-bit auto-reload stage
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lo_cnt_r <= 8'h00;
      lo_run_r <= 1'b0;
      lo_arm_r <= 1'b0;
    end else if (cfg_wr) begin
      if (wmode[M_LO_ARM]) begin
        // R3 wait for the first start bit
        lo_arm_r <= 1'b1;
        lo_run_r <= 1'b0;
      end else if (!wmode[M_LO_KEEP]) begin
        // R7 stop codes and pair-only codes idle the stage
        lo_arm_r <= 1'b0;
        lo_run_r <= 1'b0;
      end
      // R21 code 05H leaves the stage running
    end else if (halt_lo) begin
      // R16 automatic stop
      lo_arm_r <= 1'b0;
      lo_run_r <= 1'b0;
    end else if (lo_arm_r && any_start) begin
      // R3 count begins on start bit
      lo_arm_r <= 1'b0;
      lo_run_r <= 1'b1;
      lo_cnt_r <= rld_lo_r;
    end else if (lo_run_r && etu_tick_i) begin
      if (lo_tc) begin
        // R3 restart the same count
        lo_cnt_r <= rld_lo_r;
      end else begin
        // R24 one step per ETU
        lo_cnt_r <= lo_cnt_r - 8'h01;
      end
    end
  end

  // Pair or 24-bit chain
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hi_cnt_r  <= 24'h000000;
      hi_run_r  <= 1'b0;
      hi_trig_r <= 1'b0;
    end else if (cfg_wr) begin
      if (wmode[M_HI_LOAD]) begin
        // R1 R4 R8 start at the write
        hi_run_r  <= 1'b1;
        hi_trig_r <= 1'b0;
        if (wmode[M_CHAIN]) begin
          hi_cnt_r <= {rld_hi_r, rld_mid_r, rld_lo_r};
        end else begin
          hi_cnt_r <= {8'h00, rld_hi_r, rld_mid_r};
        end
      end else if (wmode[M_HI_TRIG]) begin
        // R10 R12 R13 wait for the first start bit
        hi_run_r  <= 1'b0;
        hi_trig_r <= 1'b1;
      end else begin
        // R7 R21 stop pair and chain
        hi_run_r  <= 1'b0;
        hi_trig_r <= 1'b0;
      end
    end else if (halt_hi) begin
      // R16 automatic stop, no further retrigger
      hi_run_r  <= 1'b0;
      hi_trig_r <= 1'b0;
    end else if (hi_trig_r && any_start) begin
      // R11 reloads are sampled here and at a configuration write that starts the pair or chain
      hi_run_r <= 1'b1;
      hi_cnt_r <= hi_load;
    end else if (hi_run_r && etu_tick_i) begin
      if (hi_tc) begin
        // R1 R4 one shot until reload
        hi_run_r <= 1'b0;
      end else begin
        // R24 one step per ETU
        hi_cnt_r <= hi_cnt_r - 24'h000001;
      end
    end
  end

  // Automatic stop sequencer
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tw_st_r  <= TW_IDLE;
      tw_cnt_r <= 4'h0;
    end else if (cfg_wr) begin
      // R15 armed by the write of a stop code
      tw_st_r  <= wmode[M_TW_ON] ? TW_ARM : TW_IDLE;
      tw_cnt_r <= 4'h0;
    end else begin
      case (tw_st_r)
        TW_ARM: begin
          // R15 only a received start bit counts for 85H
          if ((cfg_r == `CTOC_CFG_LO_S) ? rx_start : any_start) begin
            tw_st_r  <= TW_CNT;
            tw_cnt_r <= 4'h0;
          end
        end
        TW_CNT: begin
          if (tw_fire) begin
            tw_st_r <= TW_DONE;
          end else if (etu_tick_i) begin
            tw_cnt_r <= tw_cnt_r + 4'h1;
          end
        end
        TW_DONE: begin
          // Stays until the next configuration write
          tw_st_r <= TW_DONE;
        end
        default: begin
          tw_st_r <= TW_IDLE;
        end
      endcase
    end
  end

  // Flag update; a terminal count beats a clearing read
  always @* begin
    stat_nxt = stat_r;
    if (stat_rd) begin
      stat_nxt = 2'b00;
    end
    // R3 short flag on low terminal count
    if (lo_run_r && etu_tick_i && lo_tc && !cfg_wr && !halt_lo) begin
      stat_nxt[`CTOC_ST_SHORT] = 1'b1;
    end
    // R1 R4 long flag on pair or chain terminal count
    if (hi_run_r && etu_tick_i && hi_tc && !cfg_wr && !halt_hi) begin
      stat_nxt[`CTOC_ST_LONG] = 1'b1;
    end
  end

  // Flags and interrupt
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stat_r        <= 2'b00;
      timeout_irq_o <= 1'b0;
    end else begin
      stat_r        <= stat_nxt;
      // R1 R3 R4 interrupt while any flag stands
      timeout_irq_o <= |stat_nxt;
    end
  end

  // Read data, one cycle after the strobe, zero otherwise
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      if (addr_i == `CTOC_ADDR_CFG) begin
        rdata_o <= cfg_r;
      end else if (addr_i == `CTOC_ADDR_STAT) begin
        rdata_o <= {6'h00, stat_r};
      end else if (addr_i == `CTOC_ADDR_RUN) begin
        rdata_o <= {3'h0, cmode[M_CHAIN], hi_trig_r, lo_arm_r,
                    hi_run_r, lo_run_r};
      end else begin
        // Write-only reloads and unmapped addresses read zero
        rdata_o <= 8'h00;
      end
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule // ctoc_top

`default_nettype wire

// >>> ctoc_top_props.sv
// Port-level checks for the ETU timeout counter
`timescale 1ns/1ns
`default_nettype none
module ctoc_top_props (
  input wire logic       mclk_i,          // System clock
  input wire logic       sys_rst_i,       // Reset, high
  input wire logic [7:0] addr_i,          // Register address
  input wire logic [7:0] wdata_i,         // Write data
  input wire logic       wr_i,            // Write strobe
  input wire logic       rd_i,            // Read strobe
  input wire logic [7:0] rdata_o,         // Read data
  input wire logic       etu_tick_i,      // ETU pulse
  input wire logic       start_session_i, // Answer-to-reset session
  input wire logic       card_clk_tick_i, // Card clock pulse
  input wire logic       timeout_irq_o,   // Timeout interrupt
  input wire logic       atr_min_done_o,  // Short window done
  input wire logic       atr_max_done_o   // Long window done
);
  logic [7:0] cfg_r;     // Shadow of the configuration byte
  logic [8:0] clk_cnt_r; // Card clocks seen in the session
  wire        rd_run;    // Run register read without a tick
  assign rd_run = rd_i && addr_i == 8'h0F && !etu_tick_i;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // Follow config writes and count card clocks
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_r <= 8'h00;
      clk_cnt_r <= 9'h000;
    end else begin
      if (wr_i && addr_i == 8'h08) cfg_r <= wdata_i;
      if (card_clk_tick_i && start_session_i && clk_cnt_r != 9'h1FF)
        clk_cnt_r <= clk_cnt_r + 9'h001;
    end
  end
  cfg_read_a: assert property (rd_i && addr_i == 8'h08 |=> rdata_o == $past(cfg_r))
    else $error("config readback differs");
  reload_read_a: assert property (rd_i && addr_i inside {8'h09, 8'h0A, 8'h0B}
    |=> rdata_o == 8'h00) else $error("reload read not zero");
  stop_all_a: assert property (rd_run && cfg_r == 8'h00 |=> rdata_o[1:0] == 2'b00)
    else $error("stage running while stopped");
  pair_halt_a: assert property (rd_run && cfg_r inside {8'h05, 8'h85} |=> !rdata_o[1])
    else $error("pair running under 05");
  low_idle_a: assert property (rd_run && cfg_r inside {8'h61, 8'h71, 8'hF1}
    |=> !rdata_o[0] && !rdata_o[2]) else $error("low stage active");
  pair_start_a: assert property (wr_i && addr_i == 8'h08
    && wdata_i inside {8'h61, 8'h65} ##1 !etu_tick_i ##1 rd_run |=> rdata_o[1])
    else $error("pair not started by write");
  chain_start_a: assert property (wr_i && addr_i == 8'h08 && wdata_i == 8'h68
    ##1 !etu_tick_i ##1 rd_run |=> rdata_o[4] && rdata_o[1])
    else $error("chain not started by write");
  irq_cause_a: assert property ($rose(timeout_irq_o)
    |-> $past(etu_tick_i) || $past(etu_tick_i, 2)) else $error("interrupt without tick");
  atr_min_a: assert property ($rose(atr_min_done_o) |-> clk_cnt_r == 9'h0C8)
    else $error("short window count wrong");
  atr_max_a: assert property ($rose(atr_max_done_o) |-> clk_cnt_r == 9'h170)
    else $error("long window count wrong");
  cover property ($rose(timeout_irq_o));
  cover property ($rose(atr_max_done_o));
  cover property (wr_i && addr_i == 8'h08 && wdata_i == 8'h7C);
endmodule // ctoc_top_props
bind ctoc_top ctoc_top_props u_props (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .etu_tick_i(etu_tick_i),
  .start_session_i(start_session_i), .card_clk_tick_i(card_clk_tick_i),
  .timeout_irq_o(timeout_irq_o), .atr_min_done_o(atr_min_done_o),
  .atr_max_done_o(atr_max_done_o));
`default_nettype wire

// >>> ctoc_card_model.sv
// Card side model: start bits on the I/O line and card clock pulses
`timescale 1ns/1ns
`default_nettype none
module ctoc_card_model (
  input  wire logic mclk_i,         // System clock
  input  wire logic sys_rst_i,      // Reset, high
  input  wire logic rx_start_i,     // Send one start bit
  input  wire logic clk_run_i,      // Card clock running
  output var  logic card_io_o,      // I/O line, pulled high when idle
  output var  logic card_clk_tick_o // One pulse per card clock
);
  logic [3:0] low_cnt_r; // Cycles left in the start bit
  logic       half_r;    // Card clock divider
  // Start bit low phase, then back to the pull-up level
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_cnt_r <= 4'h0;
      half_r <= 1'b0;
      card_io_o <= 1'b1;
      card_clk_tick_o <= 1'b0;
    end else begin
      if (rx_start_i) low_cnt_r <= 4'h8;
      else if (low_cnt_r != 4'h0) low_cnt_r <= low_cnt_r - 4'h1;
      card_io_o <= !(rx_start_i || low_cnt_r > 4'h1);
      half_r <= clk_run_i && !half_r;
      card_clk_tick_o <= clk_run_i && !half_r;
    end
  end
endmodule // ctoc_card_model
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the ETU timeout counter
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        mclk_i = 1'b0;     // System clock
  logic        sys_rst_i = 1'b1;  // Reset, high
  logic [7:0]  addr_i = 8'h00;    // Register address
  logic [7:0]  wdata_i = 8'h00;   // Write data
  logic        wr_i = 1'b0;       // Write strobe
  logic        rd_i = 1'b0;       // Read strobe
  logic        etu_tick_i = 1'b0; // ETU pulse
  logic        tx_start_i = 1'b0; // Transmitted start bit
  logic        tx_busy = 1'b0;    // Transmitter owns the line
  logic        session = 1'b0;    // Answer-to-reset session
  logic        rx_req = 1'b0;     // Received start bit request
  logic        clk_run = 1'b0;    // Card clock enable
  wire         card_io;           // Card I/O line
  wire         card_tick;         // Card clock pulse
  wire  [7:0]  rdata_o;           // Read data
  wire         irq;               // Timeout interrupt
  wire         atr_min;           // Short window done
  wire         atr_max;           // Long window done
  int          err_total = 0;     // Mismatches
  int          check_count = 0;   // Comparisons
  int          n, l, m;           // Random counts
  int          seen = 0;          // Card clocks in session
  int          min_at = 0;        // Count at short window end
  int          max_at = 0;        // Count at long window end
  logic [7:0]  rd_val;            // Last read value
  logic [7:0]  codes [4] = '{8'h75, 8'hE5, 8'hF1, 8'hF5}; // Stop table
  logic [7:0]  rst_a [7] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0E, 8'h0F, 8'h33};

  ctoc_top dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .etu_tick_i(etu_tick_i), .card_io_i(card_io),
    .tx_busy_i(tx_busy), .tx_start_i(tx_start_i), .start_session_i(session),
    .card_clk_tick_i(card_tick), .timeout_irq_o(irq), .atr_min_done_o(atr_min),
    .atr_max_done_o(atr_max));
  ctoc_card_model u_card (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .rx_start_i(rx_req),
    .clk_run_i(clk_run), .card_io_o(card_io), .card_clk_tick_o(card_tick));

  // Clock, 20 ns period
  always #10 mclk_i = ~mclk_i;
  // Note where the session windows close
  always @(posedge mclk_i) begin
    if (session && card_tick) seen <= seen + 1;
    if (atr_min && min_at == 0) min_at <= seen;
    if (atr_max && max_at == 0) max_at <= seen;
  end
  // Expected run bits of the twelve-ETU table
  function automatic logic [7:0] run_exp(input logic [7:0] code, input logic stopped);
    run_exp = (code == 8'hF1) ? 8'h02 : 8'h03;
    if (stopped && code != 8'h75) run_exp = (code == 8'hE5) ? 8'h02 : 8'h00;
  endfunction
  // Verdict and end of run
  task automatic complete_run;
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Compare and report
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One write cycle, then one idle cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  // One read cycle, data taken mid-cycle after
  task automatic rchk(input logic [7:0] a, input logic [7:0] msk, input logic [7:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    rd_val = rdata_o;
    @(posedge mclk_i);
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rd_val & msk});
  endtask
  // ETU pulses every other cycle
  task automatic tick(input int k);
    repeat (k) begin
      etu_tick_i <= 1'b1;
      @(posedge mclk_i);
      etu_tick_i <= 1'b0;
      @(posedge mclk_i);
    end
  endtask
  // Start bit; a transmitted one also pulls the line, receiver masked
  task automatic sbit(input logic tx);
    tx_start_i <= tx;
    tx_busy <= tx;
    rx_req <= 1'b1;
    @(posedge mclk_i);
    tx_start_i <= 1'b0;
    rx_req <= 1'b0;
    repeat (4) @(posedge mclk_i);
    tx_busy <= 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask
  // Interrupt level, sampled mid-cycle
  task automatic irq_chk(input logic e);
    @(negedge mclk_i);
    chk("irq", {15'h0000, e}, {15'h0000, irq});
    @(posedge mclk_i);
  endtask

  // Hang guard
  initial begin
    #400000;
    err_total++;
    complete_run();
  end

  // Main sequence
  initial begin
    n = $urandom(84);
    repeat (12) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    clk_run <= 1'b1;
    @(posedge mclk_i);
    for (int i = 0; i < 7; i++) rchk(rst_a[i], 8'hFF, 8'h00);
    // Pair started by the write
    n = $urandom_range(6, 2);
    wr(8'h0A, n[7:0]);
    wr(8'h0B, 8'h00);
    wr(8'h08, 8'h61);
    rchk(8'h0F, 8'h07, 8'h02);
    tick(n - 1);
    rchk(8'h0E, 8'hFF, 8'h00);
    tick(1);
    irq_chk(1'b1);
    rchk(8'h0E, 8'hFF, 8'h02);
    irq_chk(1'b0);
    wr(8'h08, 8'h00);
    // Chained count across the byte boundary
    wr(8'h09, 8'h02);
    wr(8'h0A, 8'h01);
    wr(8'h08, 8'h68);
    rchk(8'h0F, 8'h12, 8'h12);
    tick(257);
    rchk(8'h0E, 8'hFF, 8'h00);
    tick(1);
    rchk(8'h0E, 8'hFF, 8'h02);
    wr(8'h08, 8'h00);
    // Auto-reload low stage beside the pair, low reload held
    l = $urandom_range(3, 2);
    m = 2 * l + 1;
    wr(8'h09, l[7:0]);
    wr(8'h0A, m[7:0]);
    wr(8'h08, 8'h65);
    rchk(8'h0F, 8'h07, 8'h06);
    sbit(1'b0);
    tick(l);
    rchk(8'h0E, 8'hFF, 8'h01);
    tick(l);
    rchk(8'h0E, 8'hFF, 8'h01);
    tick(1);
    rchk(8'h0E, 8'hFF, 8'h02);
    wr(8'h08, 8'h05);
    rchk(8'h0F, 8'h03, 8'h01);
    wr(8'h08, 8'h00);
    rchk(8'h0F, 8'h03, 8'h00);
    // Retriggered pair, reload changed mid-count
    m = $urandom_range(5, 3);
    wr(8'h0A, m[7:0]);
    wr(8'h08, 8'h71);
    rchk(8'h0F, 8'h03, 8'h00);
    sbit(1'b1);
    tick(m - 1);
    rchk(8'h0E, 8'hFF, 8'h00);
    sbit(1'b0);
    wr(8'h0A, m[7:0] + 8'h02);
    tick(m - 1);
    rchk(8'h0E, 8'hFF, 8'h00);
    tick(1);
    rchk(8'h0E, 8'hFF, 8'h02);
    sbit(1'b0);
    tick(m + 1);
    rchk(8'h0E, 8'hFF, 8'h00);
    tick(1);
    rchk(8'h0E, 8'hFF, 8'h02);
    wr(8'h08, 8'h00);
    // Retriggered 24-bit chain
    n = $urandom_range(4, 2);
    wr(8'h09, n[7:0]);
    wr(8'h0A, 8'h00);
    wr(8'h08, 8'h7C);
    rchk(8'h0F, 8'h03, 8'h00);
    sbit(1'b0);
    tick(n - 1);
    rchk(8'h0E, 8'hFF, 8'h00);
    tick(1);
    rchk(8'h0E, 8'hFF, 8'h02);
    tick(n);
    rchk(8'h0E, 8'hFF, 8'h00);
    sbit(1'b1);
    tick(n);
    rchk(8'h0E, 8'hFF, 8'h02);
    // Twelve-ETU stops against plain 75H
    wr(8'h09, 8'h14);
    wr(8'h0A, 8'h1E);
    for (int i = 0; i < 4; i++) begin
      wr(8'h08, 8'h00);
      wr(8'h08, codes[i]);
      sbit(i == 0);
      tick(11);
      rchk(8'h0F, 8'h03, run_exp(codes[i], 1'b0));
      tick(1);
      rchk(8'h0F, 8'h03, run_exp(codes[i], 1'b1));
    end
    // 85H stop waits for a received start, not a transmitted one
    wr(8'h08, 8'h00);
    wr(8'h08, 8'h65);
    sbit(1'b0);
    wr(8'h08, 8'h85);
    sbit(1'b1);
    tick(12);
    rchk(8'h0F, 8'h03, 8'h01);
    sbit(1'b0);
    tick(12);
    rchk(8'h0F, 8'h03, 8'h00);
    // Session windows counted in hardware
    session <= 1'b1;
    for (int c = 0; c < 1000 && !atr_max; c++) @(posedge mclk_i);
    repeat (2) @(posedge mclk_i);
    chk("short window", 16'h00C8, min_at[15:0]);
    chk("long window", 16'h0170, max_at[15:0]);
    complete_run();
  end
endmodule // testbench
`default_nettype wire
